//--- flash_cmd_device.sv
// Device end: secure-area read, deep sleep and identification commands
`timescale 1ns/1ps
// Summary of operation
// R1 - 48h: address, dummy byte, then data
// R2 - Sample on rising, shift on falling
// R3 - Read may start at any byte
// R4 - Byte address increments, low nine bits wrap
// R5 - Register chosen by address bits 15-12
// R6 - B9h alone requests deep sleep
// R7 - Sleep commands need exact byte boundary
// R8 - Sleep entered only after entry delay
// R9 - Asleep: ignore all but release/signature
// R10 - Reset always starts awake
// R11 - ABh ends on select high, exit delay
// R12 - Signature repeats while clocks continue
// R13 - ABh accepted asleep, refused during write
// R14 - 90h: two dummies, address, IDs MSB first
// R15 - Address LSB picks first ID
// R16 - IDs alternate until select rises
// R17 - 92h moves address and IDs two-bit
// R18 - 9Fh returns maker and two-byte part
// R19 - 9Fh not decoded during write cycle
// R20 - Select high abandons command, returns idle
module flash_cmd_device #(
  parameter logic [7:0] MAKER_ID  = 8'h5a, // Arbitrary value
  parameter logic [7:0] MEM_TYPE  = 8'h3c, // Arbitrary value
  parameter logic [7:0] CAPACITY  = 8'h11, // Arbitrary value
  parameter logic [7:0] SIGNATURE = 8'h2e  // Arbitrary value, also the part ID
) (
  input  wire logic                           core_clk,
  input  wire logic                           reset,
  flash_link_if.device                        link,
  input  wire logic                           write_busy,
  input  wire logic                           sec_load_en,
  input  wire logic [flash_pkg::SEC_IDX_W-1:0] sec_load_index,
  input  wire logic [7:0]                     sec_load_data,
  output logic                                deep_sleep
);
  import flash_pkg::*;

  logic [7:0]             sec_mem [0:SEC_MEM_BYTES-1];
  logic [3:0]             pin_s;
  logic [3:0]             pin_rise;
  logic [3:0]             pin_fall;
  dev_state_t             state_reg, state_next;
  sleep_state_t           sleep_reg, sleep_next;
  logic [SLEEP_CNT_W-1:0] scnt_reg, scnt_next;
  logic [7:0]             cmd_reg, cmd_next;
  logic [7:0]             in_reg, in_next;
  logic [2:0]             bit_reg, bit_next;
  logic [2:0]             byte_reg, byte_next;
  logic [23:0]            ptr_reg, ptr_next;
  logic [7:0]             out_reg, out_next;
  logic [2:0]             ocnt_reg, ocnt_next;
  logic                   oen_reg, oen_next;
  logic                   full_reg, full_next;
  logic                   dual_reg, dual_next;
  logic                   d0_reg, d0_next;
  logic                   d1_reg, d1_next;
  logic [7:0]             shifted;
  logic [7:0]             obyte;
  logic [7:0]             src_byte;
  logic [23:0]            ptr_adv;
  logic [2:0]             last_bit;
  logic [2:0]             hdr_bytes;
  logic [SEC_IDX_W-1:0]   sec_idx;
  logic                   sec_ok;
  logic                   cs_high;
  logic                   cs_rise;
  logic                   sclk_rise;
  logic                   sclk_fall;

  link_sampler #(.W(4)) u_sampler (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({link.cs_n, link.sclk, link.data_pin_one, link.data_pin_zero}),
    .sync_out (pin_s),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  assign cs_high   = pin_s[3];
  assign cs_rise   = pin_rise[3];
  assign sclk_rise = pin_rise[2]; // see R2
  assign sclk_fall = pin_fall[2];

  ////////////////////////////////////////////////////////////////////////////
  // Byte source and address advance

  always_comb
  begin
    sec_idx = {ptr_reg[13:12] - 2'd1, ptr_reg[8:0]}; // see R5
    sec_ok  = (ptr_reg[23:14] == '0) && (ptr_reg[13:12] != 2'd0) && (ptr_reg[11:9] == 3'd0);
    ptr_adv = ptr_reg;
    if (cmd_reg == SECURE_AREA_READ_CMD)
    begin
      src_byte = sec_ok ? sec_mem[sec_idx] : UNMAPPED_BYTE;
      ptr_adv  = {ptr_reg[23:9], ptr_reg[8:0] + 9'd1}; // see R4
    end
    else if (cmd_reg == MAKER_PART_ID_CMD || cmd_reg == DUAL_MAKER_PART_ID_CMD)
    begin
      src_byte = ptr_reg[0] ? SIGNATURE : MAKER_ID; // see R15
      ptr_adv  = {ptr_reg[23:1], ~ptr_reg[0]}; // see R16
    end
    else if (cmd_reg == IDENTIFICATION_CMD)
    begin
      src_byte = (ptr_reg[1:0] == 2'd0) ? MAKER_ID : ((ptr_reg[1:0] == 2'd1) ? MEM_TYPE : CAPACITY); // see R18
      ptr_adv  = (ptr_reg[1:0] == IDENT_LAST_IDX) ? 24'h000000 : ptr_reg + 24'h000001;
    end
    else
      src_byte = SIGNATURE; // see R12
    if (cmd_reg == SECURE_AREA_READ_CMD)
      hdr_bytes = SECURE_HDR_BYTES; // see R1
    else if (cmd_reg == LEGACY_SIGNATURE_CMD)
      hdr_bytes = SIGNATURE_HDR_BYTES;
    else
      hdr_bytes = MAKER_HDR_BYTES; // see R14
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer and sleep timer

  always_comb
  begin
    state_next = state_reg;
    sleep_next = sleep_reg;
    scnt_next  = scnt_reg;
    cmd_next   = cmd_reg;
    in_next    = in_reg;
    bit_next   = bit_reg;
    byte_next  = byte_reg;
    ptr_next   = ptr_reg;
    out_next   = out_reg;
    ocnt_next  = ocnt_reg;
    oen_next   = oen_reg;
    full_next  = full_reg;
    dual_next  = dual_reg;
    d0_next    = d0_reg;
    d1_next    = d1_reg;
    shifted    = dual_reg ? {in_reg[5:0], pin_s[1], pin_s[0]} : {in_reg[6:0], pin_s[0]}; // see R17
    last_bit   = dual_reg ? 3'd6 : 3'd7;
    obyte      = (ocnt_reg == 3'd0) ? src_byte : out_reg;

    case (sleep_reg)
      SL_ENTER:
        if (scnt_reg == SLEEP_CNT_W'(SLEEP_ENTRY_CYC - 1))
          sleep_next = SL_ASLEEP; // see R8
        else
          scnt_next = scnt_reg + 1'b1;
      SL_WAKE:
        if (scnt_reg == SLEEP_CNT_W'(SLEEP_EXIT_CYC - 1))
          sleep_next = SL_AWAKE; // see R11
        else
          scnt_next = scnt_reg + 1'b1;
      default: ;
    endcase

    if (cs_high)
    begin
      if (cs_rise)
      begin
        // Only a frame that ended right on the code byte counts
        if (state_reg == D_HOLD && cmd_reg == DEEP_SLEEP_CMD && sleep_reg == SL_AWAKE)
        begin
          sleep_next = SL_ENTER; // see R6 R7
          scnt_next  = '0;
        end
        if (cmd_reg == DEEP_SLEEP_RELEASE_CMD && sleep_reg != SL_AWAKE
            && (state_reg == D_HOLD || (state_reg == D_OUT && full_reg)))
        begin
          sleep_next = SL_WAKE; // see R7 R11 R12
          scnt_next  = '0;
        end
      end
      state_next = D_IDLE; // see R20
      oen_next   = 1'b0;
      full_next  = 1'b0;
      dual_next  = 1'b0;
      bit_next   = 3'd0;
      byte_next  = 3'd0;
      ocnt_next  = 3'd0;
      ptr_next   = 24'h000000;
    end
    else
    begin
      case (state_reg)
        D_IDLE:
          state_next = D_CMD;
        D_CMD:
          if (sclk_rise)
          begin
            in_next  = shifted;
            bit_next = bit_reg + 3'd1;
            if (bit_reg == 3'd7)
            begin
              cmd_next = shifted;
              if ((sleep_reg != SL_AWAKE && shifted != DEEP_SLEEP_RELEASE_CMD)
                  || (write_busy && (shifted == LEGACY_SIGNATURE_CMD || shifted == IDENTIFICATION_CMD)))
                state_next = D_SKIP; // see R9 R13 R19
              else if (shifted == DEEP_SLEEP_CMD || shifted == DEEP_SLEEP_RELEASE_CMD)
                state_next = D_HOLD;
              else if (shifted == IDENTIFICATION_CMD)
                state_next = D_OUT;
              else if (shifted == SECURE_AREA_READ_CMD || shifted == MAKER_PART_ID_CMD)
                state_next = D_ADDR;
              else if (shifted == DUAL_MAKER_PART_ID_CMD)
              begin
                state_next = D_ADDR;
                dual_next  = 1'b1; // see R17
              end
              else
                state_next = D_SKIP;
            end
          end
        D_HOLD:
          if (sclk_rise)
          begin
            // Further clocks after the release code mean a signature read
            if (cmd_reg == LEGACY_SIGNATURE_CMD)
            begin
              state_next = D_ADDR;
              in_next    = shifted;
              bit_next   = 3'd1;
            end
            else
              state_next = D_SKIP; // see R7
          end
        D_ADDR:
          if (sclk_rise)
          begin
            in_next  = shifted;
            bit_next = bit_reg + (dual_reg ? 3'd2 : 3'd1);
            if (bit_reg == last_bit)
            begin
              bit_next  = 3'd0;
              byte_next = byte_reg + 3'd1;
              if (byte_reg < 3'd3)
                ptr_next = {ptr_reg[15:0], shifted}; // see R3
              if (byte_reg == hdr_bytes - 3'd1)
                state_next = D_OUT; // see R1
            end
          end
        D_OUT:
          if (sclk_fall)
          begin
            oen_next = 1'b1;
            d1_next  = obyte[7]; // see R14
            if (dual_reg)
            begin
              d0_next  = obyte[6];
              out_next = {obyte[5:0], 2'b00};
            end
            else
              out_next = {obyte[6:0], 1'b0};
            if (ocnt_reg == 3'd0)
              ptr_next = ptr_adv; // see R4
            if (ocnt_reg == last_bit)
            begin
              ocnt_next = 3'd0;
              full_next = 1'b1;
            end
            else
              ocnt_next = ocnt_reg + (dual_reg ? 3'd2 : 3'd1);
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg <= D_IDLE;
      sleep_reg <= SL_AWAKE; // see R10
      scnt_reg  <= '0;
      cmd_reg   <= 8'h00;
      in_reg    <= 8'h00;
      bit_reg   <= 3'd0;
      byte_reg  <= 3'd0;
      ptr_reg   <= 24'h000000;
      out_reg   <= 8'h00;
      ocnt_reg  <= 3'd0;
      oen_reg   <= 1'b0;
      full_reg  <= 1'b0;
      dual_reg  <= 1'b0;
      d0_reg    <= 1'b0;
      d1_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sleep_reg <= sleep_next;
      scnt_reg  <= scnt_next;
      cmd_reg   <= cmd_next;
      in_reg    <= in_next;
      bit_reg   <= bit_next;
      byte_reg  <= byte_next;
      ptr_reg   <= ptr_next;
      out_reg   <= out_next;
      ocnt_reg  <= ocnt_next;
      oen_reg   <= oen_next;
      full_reg  <= full_next;
      dual_reg  <= dual_next;
      d0_reg    <= d0_next;
      d1_reg    <= d1_next;
    end
  end

  // Preload port stands in for the excluded program path
  always_ff @(posedge core_clk)
  begin
    if (sec_load_en)
      sec_mem[sec_load_index] <= sec_load_data;
  end

  assign deep_sleep       = (sleep_reg == SL_ASLEEP);
  assign link.dev_d1_out  = d1_reg;
  assign link.dev_d1_oe_n = ~oen_reg;
  assign link.dev_d0_out  = d0_reg;
  assign link.dev_d0_oe_n = ~(oen_reg & dual_reg);
endmodule // flash_cmd_device

//--- flash_pkg.sv
// Shared constants and state types of the serial flash command link
package flash_pkg;
  localparam logic [7:0] SECURE_AREA_READ_CMD    = 8'h48;
  localparam logic [7:0] DEEP_SLEEP_CMD          = 8'hb9;
  localparam logic [7:0] DEEP_SLEEP_RELEASE_CMD  = 8'hab;
  localparam logic [7:0] LEGACY_SIGNATURE_CMD    = 8'hab;
  localparam logic [7:0] MAKER_PART_ID_CMD       = 8'h90;
  localparam logic [7:0] DUAL_MAKER_PART_ID_CMD  = 8'h92;
  localparam logic [7:0] IDENTIFICATION_CMD      = 8'h9f;

  localparam int CLK_NS                 = 10;
  localparam int SLEEP_ENTRY_DELAY_NS   = 3000;
  localparam int SLEEP_EXIT_DELAY_NS    = 8000;
  localparam int SLEEP_ENTRY_CYC        = (SLEEP_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_EXIT_CYC         = SLEEP_EXIT_DELAY_NS / CLK_NS;
  localparam int SLEEP_CNT_W            = 16;
  localparam int SCLK_HALF_CYC          = 8;
  localparam int CS_GAP_CYC             = 4;

  localparam logic [2:0] SECURE_HDR_BYTES    = 3'd4;
  localparam logic [2:0] MAKER_HDR_BYTES     = 3'd3;
  localparam logic [2:0] SIGNATURE_HDR_BYTES = 3'd3;
  localparam logic [5:0] DUAL_HDR_BITS       = 6'd24;
  localparam logic [1:0] IDENT_LAST_IDX      = 2'd2;
  localparam int SEC_IDX_W                   = 11;
  localparam logic [8:0] SEC_BYTE_LAST       = 9'h1ff;
  localparam int SEC_MEM_BYTES               = 1536;
  localparam logic [7:0] UNMAPPED_BYTE       = 8'hff;

  typedef enum logic [5:0] {
    D_IDLE = 6'b000001,
    D_CMD  = 6'b000010,
    D_HOLD = 6'b000100,
    D_ADDR = 6'b001000,
    D_OUT  = 6'b010000,
    D_SKIP = 6'b100000
  } dev_state_t;

  typedef enum logic [3:0] {
    SL_AWAKE  = 4'b0001,
    SL_ENTER  = 4'b0010,
    SL_ASLEEP = 4'b0100,
    SL_WAKE   = 4'b1000
  } sleep_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_RUN  = 3'b010,
    H_GAP  = 3'b100
  } host_state_t;
endpackage

//--- flash_link_if.sv
// Serial link between flash host and flash device, with pin resolution
`timescale 1ns/1ps
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic host_d0_out;
  logic host_d0_oe_n;
  logic host_d1_out;
  logic host_d1_oe_n;
  logic dev_d0_out;
  logic dev_d0_oe_n;
  logic dev_d1_out;
  logic dev_d1_oe_n;
  logic data_pin_zero;
  logic data_pin_one;

  // Undriven pins read as pulled high
  assign data_pin_zero = !host_d0_oe_n ? host_d0_out : (!dev_d0_oe_n ? dev_d0_out : 1'b1);
  assign data_pin_one  = !host_d1_oe_n ? host_d1_out : (!dev_d1_oe_n ? dev_d1_out : 1'b1);

  modport host (output cs_n, sclk, host_d0_out, host_d0_oe_n, host_d1_out, host_d1_oe_n,
                input data_pin_zero, data_pin_one);
  modport device (input cs_n, sclk, data_pin_zero, data_pin_one,
                  output dev_d0_out, dev_d0_oe_n, dev_d1_out, dev_d1_oe_n);
endinterface

//--- link_sampler.sv
// Two-stage synchroniser with edge detection for link pins
`timescale 1ns/1ps
module link_sampler #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] prev_reg;

  if (W < 1) $error("link_sampler needs W >= 1");

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      // Select and data idle high; a false sclk fall lands while deselected
      meta_reg <= '1;
      sync_out <= '1;
      prev_reg <= '1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
      prev_reg <= sync_out;
    end
  end

  assign rise = sync_out & ~prev_reg;
  assign fall = ~sync_out & prev_reg;
endmodule // link_sampler

//--- flash_cmd_host.sv
// Host end: frames one command per request and returns read bytes
`timescale 1ns/1ps
module flash_cmd_host #(
  parameter int RD_LEN_W = 16
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  flash_link_if.host               link,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic [7:0]          req_cmd,
  input  wire logic [23:0]         req_addr,
  input  wire logic [RD_LEN_W-1:0] req_rd_len,
  output logic                     rd_valid,
  output logic [7:0]               rd_data,
  output logic                     done
);
  import flash_pkg::*;

  host_state_t          state_reg, state_next;
  logic                 cs_n_reg, cs_n_next;
  logic                 sclk_reg, sclk_next;
  logic                 d0_reg, d0_next;
  logic                 d1_reg, d1_next;
  logic                 d0_drv_reg, d0_drv_next;
  logic                 d1_drv_reg, d1_drv_next;
  logic [39:0]          tx_reg, tx_next;
  logic [5:0]           tx_left_reg, tx_left_next;
  logic                 step2_reg, step2_next;
  logic                 dual_reg, dual_next;
  logic                 wake_reg, wake_next;
  logic [RD_LEN_W-1:0]  rx_left_reg, rx_left_next;
  logic [7:0]           rx_reg, rx_next;
  logic [2:0]           rx_cnt_reg, rx_cnt_next;
  logic [3:0]           div_reg, div_next;
  logic [SLEEP_CNT_W-1:0] gap_reg, gap_next;
  logic                 rdv_next;
  logic [7:0]           rdd_next;
  logic                 done_next;
  logic [2:0]           hdr;
  logic [1:0]           pin_s;

  if (RD_LEN_W < 1) $error("flash_cmd_host needs RD_LEN_W >= 1");

  link_sampler #(.W(2)) u_sampler (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({link.data_pin_one, link.data_pin_zero}),
    .sync_out (pin_s),
    .rise     (),
    .fall     ()
  );

  always_comb
  begin
    state_next   = state_reg;
    cs_n_next    = cs_n_reg;
    sclk_next    = sclk_reg;
    d0_next      = d0_reg;
    d1_next      = d1_reg;
    d0_drv_next  = d0_drv_reg;
    d1_drv_next  = d1_drv_reg;
    tx_next      = tx_reg;
    tx_left_next = tx_left_reg;
    step2_next   = step2_reg;
    dual_next    = dual_reg;
    wake_next    = wake_reg;
    rx_left_next = rx_left_reg;
    rx_next      = rx_reg;
    rx_cnt_next  = rx_cnt_reg;
    div_next     = div_reg;
    gap_next     = gap_reg;
    rdv_next     = 1'b0;
    rdd_next     = rd_data;
    done_next    = 1'b0;
    if (req_cmd == SECURE_AREA_READ_CMD)
      hdr = SECURE_HDR_BYTES;
    else if (req_cmd == MAKER_PART_ID_CMD || req_cmd == DUAL_MAKER_PART_ID_CMD)
      hdr = MAKER_HDR_BYTES;
    else if (req_cmd == LEGACY_SIGNATURE_CMD && req_rd_len != '0)
      hdr = SIGNATURE_HDR_BYTES;
    else
      hdr = 3'd0;
    case (state_reg)
      H_IDLE:
        if (req_valid)
        begin
          state_next   = H_RUN;
          cs_n_next    = 1'b0;
          tx_next      = {req_cmd, (hdr == MAKER_HDR_BYTES) ? {16'h0000, req_addr[7:0]} : req_addr, 8'h00};
          tx_left_next = {hdr, 3'd0} + 6'd8;
          d0_next      = req_cmd[7];
          d0_drv_next  = 1'b1;
          dual_next    = (req_cmd == DUAL_MAKER_PART_ID_CMD);
          wake_next    = (req_cmd == DEEP_SLEEP_RELEASE_CMD);
          rx_left_next = req_rd_len;
          rx_cnt_next  = 3'd0;
          div_next     = 4'd0;
        end
      H_RUN:
        if (div_reg != 4'(SCLK_HALF_CYC - 1))
          div_next = div_reg + 4'd1;
        else
        begin
          div_next = 4'd0;
          if (!sclk_reg)
          begin
            sclk_next = 1'b1;
            if (tx_left_reg != 6'd0)
            begin
              step2_next   = dual_reg && tx_left_reg <= DUAL_HDR_BITS;
              tx_left_next = tx_left_reg - ((dual_reg && tx_left_reg <= DUAL_HDR_BITS) ? 6'd2 : 6'd1);
            end
            else if (rx_left_reg != '0)
            begin
              rx_next     = dual_reg ? {rx_reg[5:0], pin_s[1], pin_s[0]} : {rx_reg[6:0], pin_s[1]};
              rx_cnt_next = rx_cnt_reg + (dual_reg ? 3'd2 : 3'd1);
              if (rx_cnt_reg == (dual_reg ? 3'd6 : 3'd7))
              begin
                rdv_next     = 1'b1;
                rdd_next     = rx_next;
                rx_left_next = rx_left_reg - 1'b1;
              end
            end
          end
          else
          begin
            sclk_next = 1'b0;
            if (tx_left_reg != 6'd0)
            begin
              tx_next     = step2_reg ? {tx_reg[37:0], 2'b00} : {tx_reg[38:0], 1'b0};
              d1_drv_next = dual_reg && tx_left_reg <= DUAL_HDR_BITS;
              d1_next     = tx_next[39];
              d0_next     = (dual_reg && tx_left_reg <= DUAL_HDR_BITS) ? tx_next[38] : tx_next[39];
            end
            else
            begin
              // Release both pins before the device starts driving
              d0_drv_next = 1'b0;
              d1_drv_next = 1'b0;
              if (rx_left_reg == '0)
              begin
                cs_n_next  = 1'b1;
                state_next = H_GAP;
                gap_next   = '0;
              end
            end
          end
        end
      H_GAP:
        if (gap_reg == (wake_reg ? SLEEP_CNT_W'(SLEEP_EXIT_CYC - 1) : SLEEP_CNT_W'(CS_GAP_CYC - 1))) // see R11
        begin
          state_next = H_IDLE;
          done_next  = 1'b1;
        end
        else
          gap_next = gap_reg + 1'b1;
      default: state_next = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg   <= H_IDLE;
      cs_n_reg    <= 1'b1;
      sclk_reg    <= 1'b0;
      d0_reg      <= 1'b0;
      d1_reg      <= 1'b0;
      d0_drv_reg  <= 1'b0;
      d1_drv_reg  <= 1'b0;
      tx_reg      <= '0;
      tx_left_reg <= 6'd0;
      step2_reg   <= 1'b0;
      dual_reg    <= 1'b0;
      wake_reg    <= 1'b0;
      rx_left_reg <= '0;
      rx_reg      <= 8'h00;
      rx_cnt_reg  <= 3'd0;
      div_reg     <= 4'd0;
      gap_reg     <= '0;
      rd_valid    <= 1'b0;
      rd_data     <= 8'h00;
      done        <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cs_n_reg    <= cs_n_next;
      sclk_reg    <= sclk_next;
      d0_reg      <= d0_next;
      d1_reg      <= d1_next;
      d0_drv_reg  <= d0_drv_next;
      d1_drv_reg  <= d1_drv_next;
      tx_reg      <= tx_next;
      tx_left_reg <= tx_left_next;
      step2_reg   <= step2_next;
      dual_reg    <= dual_next;
      wake_reg    <= wake_next;
      rx_left_reg <= rx_left_next;
      rx_reg      <= rx_next;
      rx_cnt_reg  <= rx_cnt_next;
      div_reg     <= div_next;
      gap_reg     <= gap_next;
      rd_valid    <= rdv_next;
      rd_data     <= rdd_next;
      done        <= done_next;
    end
  end

  assign req_ready         = (state_reg == H_IDLE);
  assign link.cs_n         = cs_n_reg;
  assign link.sclk         = sclk_reg;
  assign link.host_d0_out  = d0_reg;
  assign link.host_d0_oe_n = ~d0_drv_reg;
  assign link.host_d1_out  = d1_reg;
  assign link.host_d1_oe_n = ~d1_drv_reg;
endmodule // flash_cmd_host

//--- flash_link_props.sv
// Assertions on the wires of the flash command link
`timescale 1ns/1ps
module flash_link_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_d0_oe_n,
  input wire logic host_d1_oe_n,
  input wire logic dev_d0_oe_n,
  input wire logic dev_d1_oe_n,
  input wire logic data_pin_zero,
  input wire logic data_pin_one
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  idle_clk_low_a: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  dev_release_a: assert property ($rose(cs_n) |-> ##[1:8] (dev_d0_oe_n && dev_d1_oe_n))
    else $error("device drives after deselect");
  pin0_single_a: assert property (host_d0_oe_n || dev_d0_oe_n)
    else $error("both ends drive pin zero");
  pin1_single_a: assert property (host_d1_oe_n || dev_d1_oe_n)
    else $error("both ends drive pin one");
  clk_high_a: assert property ($rose(sclk) |-> sclk [*8])
    else $error("short sclk high phase");
  clk_low_a: assert property ($fell(sclk) |-> (!sclk) [*8])
    else $error("short sclk low phase");
  dev_out_hold_a: assert property (sclk && $past(sclk) && !dev_d1_oe_n && !$past(dev_d1_oe_n) |-> $stable(data_pin_one))
    else $error("device output moved while sclk high");
  host_out_hold_a: assert property (sclk && $past(sclk) && !host_d0_oe_n |-> $stable(data_pin_zero))
    else $error("host output moved while sclk high");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("short deselect gap");
  sel_c: cover property ($fell(cs_n));
  dev_out_c: cover property ($fell(dev_d1_oe_n));
  dual_out_c: cover property (!dev_d0_oe_n);
endmodule // flash_link_props

//--- test_flash_id_powerdown_secreg_read.sv
// Self-checking bench for both ends of the flash command link
`timescale 1ns/1ps
module test_flash_id_powerdown_secreg_read;
  import flash_pkg::*;
  // Arbitrary identity values
  localparam logic [7:0] MK = 8'hc3;
  localparam logic [7:0] TY = 8'h4d;
  localparam logic [7:0] CP = 8'h27;
  localparam logic [7:0] SG = 8'h71;
  typedef struct {logic [7:0] cmd; logic [23:0] addr; int n; logic [31:0] e;} row_t;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        write_busy = 1'b0;
  logic        sec_load_en = 1'b0;
  logic [10:0] sec_load_index = '0;
  logic [7:0]  sec_load_data = '0;
  logic        req_valid = 1'b0;
  logic [7:0]  req_cmd = '0;
  logic [23:0] req_addr = '0;
  logic [15:0] req_rd_len = '0;
  logic        req_ready, rd_valid, done, deep_sleep;
  logic [7:0]  rd_data;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [7:0]  got [$];
  logic [18:0] ld [4] = '{{11'd1022, 8'h11}, {11'd1023, 8'h22}, {11'd512, 8'h33}, {11'd1029, 8'h44}};
  row_t        rows [9] = '{
    '{IDENTIFICATION_CMD, 24'h0, 4, {MK, TY, CP, MK}},
    '{MAKER_PART_ID_CMD, 24'h0, 3, {MK, SG, MK, 8'h0}},
    '{MAKER_PART_ID_CMD, 24'h1, 2, {SG, MK, 16'h0}},
    '{DUAL_MAKER_PART_ID_CMD, 24'h0, 3, {MK, SG, MK, 8'h0}},
    '{DUAL_MAKER_PART_ID_CMD, 24'h1, 2, {SG, MK, 16'h0}},
    '{LEGACY_SIGNATURE_CMD, 24'h0, 2, {SG, SG, 16'h0}},
    '{SECURE_AREA_READ_CMD, 24'h0021fe, 3, {24'h112233, 8'h0}},
    '{SECURE_AREA_READ_CMD, 24'h003005, 1, {8'h44, 24'h0}},
    '{SECURE_AREA_READ_CMD, 24'h004000, 1, {UNMAPPED_BYTE, 24'h0}}};
  flash_link_if link ();
  flash_cmd_device #(.MAKER_ID(MK), .MEM_TYPE(TY), .CAPACITY(CP), .SIGNATURE(SG)) i_flash_cmd_device (
    .core_clk(core_clk), .reset(reset), .link(link), .write_busy(write_busy), .sec_load_en(sec_load_en),
    .sec_load_index(sec_load_index), .sec_load_data(sec_load_data), .deep_sleep(deep_sleep));
  flash_cmd_host i_flash_cmd_host (.core_clk(core_clk), .reset(reset), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_rd_len(req_rd_len),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
  flash_link_props i_flash_link_props (.core_clk(core_clk), .reset(reset), .cs_n(link.cs_n), .sclk(link.sclk),
    .host_d0_oe_n(link.host_d0_oe_n), .host_d1_oe_n(link.host_d1_oe_n), .dev_d0_oe_n(link.dev_d0_oe_n),
    .dev_d1_oe_n(link.dev_d1_oe_n), .data_pin_zero(link.data_pin_zero), .data_pin_one(link.data_pin_one));
  ////////////////////////////////////////
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, far above the roughly 13k cycles the run needs
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      wrap_up();
    end
    if (rd_valid === 1'b1) got.push_back(rd_data);
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic run(input logic [7:0] c, input logic [23:0] a, input int n, input logic [31:0] e);
    got.delete();
    req_cmd <= c;
    req_addr <= a;
    req_rd_len <= 16'(n);
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(negedge core_clk) check({7'h0, req_ready}, 8'h00);
    for (int t = 0; t < 20000 && done !== 1'b1; t++) @(negedge core_clk);
    @(posedge core_clk);
    check(8'(got.size()), 8'(n));
    for (int i = 0; i < n; i++) check(got[i], e[31-8*i -: 8]);
  endtask
  // Sleep takes effect only once the entry delay has run out
  task automatic sleep_now();
    run(DEEP_SLEEP_CMD, 24'h0, 0, 32'h0);
    check({7'h0, deep_sleep}, 8'h00);
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge core_clk);
    check({7'h0, deep_sleep}, 8'h01);
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({7'h0, deep_sleep}, 8'h00);
  endtask
  ////////////////////////////////////////
  initial
  begin
    do_reset();
    sec_load_en <= 1'b1;
    foreach (ld[i])
    begin
      sec_load_index <= ld[i][18:8];
      sec_load_data <= ld[i][7:0];
      @(posedge core_clk);
    end
    sec_load_en <= 1'b0;
    foreach (rows[i]) run(rows[i].cmd, rows[i].addr, rows[i].n, rows[i].e);
    run(DEEP_SLEEP_CMD, 24'h0, 1, {8'hff, 24'h0});
    repeat (SLEEP_ENTRY_CYC + 10) @(posedge core_clk);
    check({7'h0, deep_sleep}, 8'h00);
    sleep_now();
    run(IDENTIFICATION_CMD, 24'h0, 1, {8'hff, 24'h0});
    do_reset();
    sleep_now();
    run(LEGACY_SIGNATURE_CMD, 24'h0, 1, {SG, 24'h0});
    check({7'h0, deep_sleep}, 8'h00);
    write_busy <= 1'b1;
    run(IDENTIFICATION_CMD, 24'h0, 1, {8'hff, 24'h0});
    run(LEGACY_SIGNATURE_CMD, 24'h0, 1, {8'hff, 24'h0});
    write_busy <= 1'b0;
    run(IDENTIFICATION_CMD, 24'h0, 3, {MK, TY, CP, 8'h0});
    wrap_up();
  end
endmodule // test_flash_id_powerdown_secreg_read
